// [rtl/qhd_link_decode.sv]
`timescale 1ns/1ns
module qhd_link_decode
    import qhd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pointer load
    input wire logic load,
    input wire logic [31:0] dword,
    // Decoded pointer
    output logic [26:0] addr,
    output qhd_kind_t kind,
    output logic valid
);

    typedef struct packed {
        logic [26:0] addr;
        qhd_kind_t kind;
        logic valid;
    } qhd_link_state_t;

    qhd_link_state_t st_reg;
    qhd_link_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.addr = dword[31:LNK_ADDR_LSB];
            st_next.kind = qhd_kind_t'(dword[LNK_KIND_LSB +: 2]);
            st_next.valid = ~dword[LNK_TERM_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg <= '{addr: 27'h0, kind: QHD_KIND_ISOCH, valid: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign addr = st_reg.addr;
    assign kind = st_reg.kind;
    assign valid = st_reg.valid;

    term_blocks_a: assert property (@(posedge clock) disable iff (!rstn)
        load && dword[LNK_TERM_BIT] |=> !valid) else $error("terminated pointer marked valid");

endmodule

// [rtl/qhd_nak_counter.sv]
`timescale 1ns/1ns
module qhd_nak_counter
    import qhd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic reload,
    input wire logic [3:0] reload_value,
    input wire logic nak_seen,
    // Count
    output logic [3:0] count,
    output logic exhausted
);

    typedef struct packed {
        logic [3:0] count;
        logic exhausted;
    } qhd_nak_state_t;

    qhd_nak_state_t st_reg;
    qhd_nak_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (reload) begin
            st_next.count = reload_value;
        end else if (nak_seen && st_reg.count != 4'h0) begin
            st_next.count = st_reg.count - 4'h1;
        end
        st_next.exhausted = (st_next.count == 4'h0);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg <= '{count: QHD_NAK_RST, exhausted: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.count;
    assign exhausted = st_reg.exhausted;

    nak_reload_a: assert property (@(posedge clock) disable iff (!rstn)
        reload |=> count == $past(reload_value)) else $error("nak counter not reloaded");

    nak_step_a: assert property (@(posedge clock) disable iff (!rstn)
        !reload && nak_seen && count != 4'h0 |=> count == $past(count) - 4'h1)
        else $error("nak counter did not step down");

endmodule

// [rtl/qhd_pkg.sv]
package qhd_pkg;

    // ------------------------------------------------------------
    // Link pointer dword layout
    // ------------------------------------------------------------
    localparam int LNK_ADDR_LSB = 5;
    localparam int LNK_KIND_LSB = 1;
    localparam int LNK_TERM_BIT = 0;

    typedef enum logic [1:0] {
        QHD_KIND_ISOCH = 2'h0,
        QHD_KIND_QH = 2'h1,
        QHD_KIND_SPLIT_ISOCH = 2'h2,
        QHD_KIND_SPAN_NODE = 2'h3
    } qhd_kind_t;

    // ------------------------------------------------------------
    // Endpoint characteristics dword layout
    // ------------------------------------------------------------
    localparam int EC_NAK_RELOAD_LSB = 28;
    localparam int EC_CTRL_EP_BIT = 27;
    localparam int EC_MAX_PKT_LSB = 16;
    localparam int EC_RECLAIM_BIT = 15;
    localparam int EC_TOGGLE_CTRL_BIT = 14;
    localparam int EC_SPEED_LSB = 12;
    localparam int EC_EP_NUM_LSB = 8;
    localparam int EC_INACT_BIT = 7;
    localparam int EC_DEV_ADDR_LSB = 0;

    typedef enum logic [1:0] {
        QHD_SPEED_FULL = 2'h0,
        QHD_SPEED_LOW = 2'h1,
        QHD_SPEED_HIGH = 2'h2,
        QHD_SPEED_RSVD = 2'h3
    } qhd_speed_t;

    // ------------------------------------------------------------
    // Endpoint capabilities dword layout
    // ------------------------------------------------------------
    localparam int CAP_MULT_LSB = 30;
    localparam int CAP_PORT_LSB = 23;
    localparam int CAP_HUB_LSB = 16;
    localparam int CAP_CS_MASK_LSB = 8;
    localparam int CAP_SS_MASK_LSB = 0;
    localparam logic [1:0] QHD_MULT_RSVD = 2'h0;

    // ------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------
    localparam logic [10:0] QHD_MAX_PKT_LIMIT = 11'h400;
    localparam logic [3:0] QHD_NAK_RST = 4'h0;
    localparam logic [7:0] QHD_MASK_RST = 8'h00;

endpackage

// [rtl/qhd_queue_head.sv]
`timescale 1ns/1ns
// Function
// - Link type code 00/01/10/11 means isochronous, queue head, split isochronous, span node.
// - A terminated link pointer is invalid and never followed.
// - Working NAK counter reloads from the queue head's reload value.
// - Each data packet is limited to max packet bytes, itself at most 1024.
// - A queue head with the reclamation flag marks the reclamation list head.
// - Toggle control 0 keeps stored toggle; 1 takes it from the element descriptor.
// - Speed code 00 full, 01 low, 10 high, 11 reserved.
// - Multiplier 01/10/11 gives one, two, three transactions; 00 is reserved.
// - Split transactions go to the translator port given by the queue head.
// - Split transactions address the translator hub given by the queue head.
// - Complete-splits only in micro-frames set in the complete-split mask.
// - Start-splits only in micro-frames set in the start-split mask.
// - Current element link locates the element descriptor in progress.
// - NAK counter decrements on each NAK or NYET handshake until it reaches zero, then holds.
// - Complete-split progress mask tracks which complete-splits were done.
// - Split frame tag tracks the progress of an interrupt split.
// - Split byte tally counts bytes moved in an IN or OUT split.
module qhd_queue_head
    import qhd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Descriptor load
    input wire logic qh_load,
    input wire logic [31:0] horizontal_dword,
    input wire logic [31:0] ep_char_dword,
    input wire logic [31:0] ep_cap_dword,
    input wire logic [31:0] current_dword,
    input wire logic overlay_toggle,
    input wire logic [7:0] overlay_progress,
    input wire logic [4:0] overlay_frame_tag,
    input wire logic [6:0] overlay_byte_tally,
    // Element descriptor load
    input wire logic elem_load,
    input wire logic elem_toggle,
    // Transaction results
    input wire logic xact_done,
    input wire logic xact_nak_nyet,
    input wire logic xact_ack,
    // Micro-frame schedule
    input wire logic uframe_tick,
    input wire logic [2:0] uframe_index,
    input wire logic [4:0] frame_index,
    input wire logic ss_issued,
    input wire logic cs_done,
    input wire logic [6:0] split_bytes,
    // Packet length check
    input wire logic pkt_check,
    input wire logic [10:0] pkt_len,
    // Service
    input wire logic service_done,
    // Horizontal and current links
    output logic [26:0] horizontal_link,
    output qhd_kind_t descriptor_kind,
    output logic horizontal_valid,
    output logic [26:0] current_element_link,
    output logic follow_next,
    // Endpoint and token fields
    output logic [6:0] device_address,
    output logic [3:0] endpoint_number,
    output logic [10:0] token_addr,
    output qhd_speed_t endpoint_speed,
    output logic speed_reserved,
    output logic [10:0] max_packet_bytes,
    output logic control_endpoint,
    output logic reclaim_head,
    output logic inactivate_next,
    output logic data_toggle,
    // Transaction budget
    output logic [1:0] transactions_per_microframe,
    output logic [1:0] xact_remaining,
    output logic mult_reserved,
    // Split state
    output logic [6:0] tt_port_number,
    output logic [6:0] tt_hub_address,
    output logic [7:0] start_split_mask,
    output logic [7:0] complete_split_mask,
    output logic ss_go,
    output logic cs_go,
    output logic [7:0] complete_split_progress,
    output logic [4:0] split_frame_tag,
    output logic [6:0] split_byte_tally,
    // Packet check and NAK state
    output logic pkt_ok,
    output logic [10:0] pkt_limit,
    output logic [3:0] nak_count,
    output logic nak_exhausted
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] nak_reload_value;
        logic ctrl_ep;
        logic [10:0] max_pkt;
        logic reclaim;
        logic toggle_ctrl;
        qhd_speed_t speed;
        logic speed_rsvd;
        logic [3:0] ep_num;
        logic inact;
        logic [6:0] dev_addr;
        logic [10:0] token;
        logic [1:0] mult;
        logic mult_rsvd;
        logic [1:0] xact_left;
        logic [6:0] tt_port;
        logic [6:0] tt_hub;
        logic [7:0] cs_mask;
        logic [7:0] ss_mask;
        logic toggle;
        logic [7:0] progress;
        logic [4:0] frame_tag;
        logic [6:0] byte_tally;
        logic ss_go;
        logic cs_go;
        logic pkt_ok;
        logic [10:0] pkt_limit;
        logic follow;
    } qhd_state_t;

    qhd_state_t st_reg;
    qhd_state_t st_next;

    // ------------------------------------------------------------
    // Link pointers and NAK counter
    // ------------------------------------------------------------
    qhd_link_decode u_horizontal (
        .clock(clock),
        .rstn(rstn),
        .load(qh_load),
        .dword(horizontal_dword),
        .addr(horizontal_link),
        .kind(descriptor_kind),
        .valid(horizontal_valid)
    );

    // The current element link carries no type code; only its address is used.
    qhd_link_decode u_current (
        .clock(clock),
        .rstn(rstn),
        .load(qh_load),
        .dword(current_dword),
        .addr(current_element_link),
        .kind(),
        .valid()
    );

    qhd_nak_counter u_nak (
        .clock(clock),
        .rstn(rstn),
        .reload(qh_load),
        .reload_value(ep_char_dword[EC_NAK_RELOAD_LSB +: 4]),
        .nak_seen(xact_done && xact_nak_nyet),
        .count(nak_count),
        .exhausted(nak_exhausted)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic is_split;
    logic [1:0] cap_mult;

    assign is_split = (st_reg.speed == QHD_SPEED_FULL) || (st_reg.speed == QHD_SPEED_LOW);
    assign cap_mult = ep_cap_dword[CAP_MULT_LSB +: 2];

    always_comb begin
        st_next = st_reg;
        st_next.ss_go = 1'b0;
        st_next.cs_go = 1'b0;
        st_next.follow = 1'b0;
        if (qh_load) begin
            st_next.nak_reload_value = ep_char_dword[EC_NAK_RELOAD_LSB +: 4];
            st_next.max_pkt = ep_char_dword[EC_MAX_PKT_LSB +: 11];
            st_next.reclaim = ep_char_dword[EC_RECLAIM_BIT];
            st_next.toggle_ctrl = ep_char_dword[EC_TOGGLE_CTRL_BIT];
            st_next.speed = qhd_speed_t'(ep_char_dword[EC_SPEED_LSB +: 2]);
            st_next.speed_rsvd = (ep_char_dword[EC_SPEED_LSB +: 2] == QHD_SPEED_RSVD);
            // High-speed heads ignore the control and inactivate flags set by software.
            st_next.ctrl_ep = ep_char_dword[EC_CTRL_EP_BIT] && !ep_char_dword[EC_SPEED_LSB + 1];
            st_next.inact = ep_char_dword[EC_INACT_BIT] && !ep_char_dword[EC_SPEED_LSB + 1];
            st_next.ep_num = ep_char_dword[EC_EP_NUM_LSB +: 4];
            st_next.dev_addr = ep_char_dword[EC_DEV_ADDR_LSB +: 7];
            st_next.token = {ep_char_dword[EC_EP_NUM_LSB +: 4], ep_char_dword[EC_DEV_ADDR_LSB +: 7]};
            st_next.mult = cap_mult;
            st_next.mult_rsvd = (cap_mult == QHD_MULT_RSVD);
            st_next.xact_left = cap_mult;
            st_next.tt_port = ep_cap_dword[CAP_PORT_LSB +: 7];
            st_next.tt_hub = ep_cap_dword[CAP_HUB_LSB +: 7];
            st_next.cs_mask = ep_cap_dword[CAP_CS_MASK_LSB +: 8];
            st_next.ss_mask = ep_cap_dword[CAP_SS_MASK_LSB +: 8];
            st_next.toggle = overlay_toggle;
            st_next.progress = overlay_progress;
            st_next.frame_tag = overlay_frame_tag;
            st_next.byte_tally = overlay_byte_tally;
        end else begin
            if (elem_load && st_reg.toggle_ctrl) begin
                st_next.toggle = elem_toggle;
            end else if (xact_done && xact_ack) begin
                st_next.toggle = ~st_reg.toggle;
            end
            if (xact_done && st_reg.xact_left != 2'h0) begin
                st_next.xact_left = st_reg.xact_left - 2'h1;
            end
            if (uframe_tick) begin
                // A fresh micro-frame restores the per-micro-frame budget.
                st_next.xact_left = st_reg.mult;
                st_next.ss_go = is_split && st_reg.ss_mask[uframe_index];
                st_next.cs_go = is_split && st_reg.cs_mask[uframe_index];
            end
            // A start-split opens a new split and so wins over a complete-split or data in the same cycle.
            if (ss_issued) begin
                st_next.frame_tag = frame_index;
                st_next.progress = QHD_MASK_RST;
                st_next.byte_tally = 7'h00;
            end else begin
                if (cs_done) begin
                    st_next.progress = st_reg.progress | (8'h01 << uframe_index);
                end
                if (xact_done && !xact_nak_nyet) begin
                    st_next.byte_tally = 7'(st_reg.byte_tally + split_bytes);
                end
            end
            if (pkt_check) begin
                // The field can encode more than the bus allows, so both bounds apply.
                st_next.pkt_limit = (st_reg.max_pkt > QHD_MAX_PKT_LIMIT) ? QHD_MAX_PKT_LIMIT : st_reg.max_pkt;
                st_next.pkt_ok = (pkt_len <= st_reg.max_pkt) && (pkt_len <= QHD_MAX_PKT_LIMIT);
            end
            if (service_done) begin
                st_next.follow = horizontal_valid;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign follow_next = st_reg.follow;
    assign device_address = st_reg.dev_addr;
    assign endpoint_number = st_reg.ep_num;
    assign token_addr = st_reg.token;
    assign endpoint_speed = st_reg.speed;
    assign speed_reserved = st_reg.speed_rsvd;
    assign max_packet_bytes = st_reg.max_pkt;
    assign control_endpoint = st_reg.ctrl_ep;
    assign reclaim_head = st_reg.reclaim;
    assign inactivate_next = st_reg.inact;
    assign data_toggle = st_reg.toggle;
    assign transactions_per_microframe = st_reg.mult;
    assign xact_remaining = st_reg.xact_left;
    assign mult_reserved = st_reg.mult_rsvd;
    assign tt_port_number = st_reg.tt_port;
    assign tt_hub_address = st_reg.tt_hub;
    assign start_split_mask = st_reg.ss_mask;
    assign complete_split_mask = st_reg.cs_mask;
    assign ss_go = st_reg.ss_go;
    assign cs_go = st_reg.cs_go;
    assign complete_split_progress = st_reg.progress;
    assign split_frame_tag = st_reg.frame_tag;
    assign split_byte_tally = st_reg.byte_tally;
    assign pkt_ok = st_reg.pkt_ok;
    assign pkt_limit = st_reg.pkt_limit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence load_with_toggle_ctrl_s;
        qh_load && ep_char_dword[EC_TOGGLE_CTRL_BIT];
    endsequence

    sequence elem_arrives_s;
        elem_load && !qh_load && st_reg.toggle_ctrl;
    endsequence

    kind_decode_a: assert property (qh_load |=> descriptor_kind == $past(horizontal_dword[LNK_KIND_LSB +: 2]))
        else $error("descriptor kind wrong");
    toggle_take_a: assert property (load_with_toggle_ctrl_s ##2 elem_arrives_s
        |=> data_toggle == $past(elem_toggle)) else $error("toggle not taken from element");
    toggle_keep_a: assert property (elem_load && !qh_load && !st_reg.toggle_ctrl && !xact_done
        |=> $stable(data_toggle)) else $error("stored toggle overwritten");
    pkt_bound_a: assert property (pkt_check && !qh_load && pkt_len > QHD_MAX_PKT_LIMIT |=> !pkt_ok)
        else $error("oversize packet accepted");
    speed_rsvd_a: assert property (qh_load |=> speed_reserved == ($past(ep_char_dword[13:12]) == 2'h3))
        else $error("reserved speed not flagged");
    ss_gate_a: assert property (ss_go |-> $past(st_reg.ss_mask[uframe_index]) && $past(uframe_tick))
        else $error("start split outside mask");
    cs_gate_a: assert property (cs_go |-> $past(st_reg.cs_mask[uframe_index]) && $past(uframe_tick))
        else $error("complete split outside mask");
    follow_gate_a: assert property (follow_next |-> $past(service_done) && horizontal_valid)
        else $error("followed a terminated link");
    frame_tag_a: assert property (ss_issued && !qh_load |=> split_frame_tag == $past(frame_index))
        else $error("frame tag not captured");
    token_fields_a: assert property (qh_load |=> token_addr == {$past(ep_char_dword[11:8]),
        $past(ep_char_dword[6:0])}) else $error("token address wrong");
    mult_budget_a: assert property (uframe_tick && !qh_load |=> xact_remaining == transactions_per_microframe)
        else $error("budget not restored");

    sequence split_start_s;
        ss_issued && !qh_load;
    endsequence

    reclaim_flag_a: assert property (qh_load |=> reclaim_head == $past(ep_char_dword[EC_RECLAIM_BIT]))
        else $error("reclaim flag wrong");

    tt_port_a: assert property (qh_load |=> tt_port_number == $past(ep_cap_dword[CAP_PORT_LSB +: 7]))
        else $error("port number wrong");
    tt_hub_a: assert property (qh_load |=> tt_hub_address == $past(ep_cap_dword[CAP_HUB_LSB +: 7]))
        else $error("hub address wrong");

    cur_link_a: assert property (qh_load |=> current_element_link == $past(current_dword[31:5]))
        else $error("current link wrong");

    cs_progress_a: assert property (cs_done && !ss_issued && !qh_load
        |=> complete_split_progress[$past(uframe_index)]) else $error("progress bit not set");

    tally_clear_a: assert property (split_start_s |=> split_byte_tally == 7'h00)
        else $error("byte tally not cleared");

    pkt_limit_a: assert property (pkt_check && !qh_load |=> pkt_limit <= QHD_MAX_PKT_LIMIT)
        else $error("packet limit above bus bound");

endmodule

// [tb/qhd_queue_head_tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module qhd_queue_head_tb_top;
    import qhd_pkg::*;
    localparam logic [7:0] SSM = 8'h05;
    localparam logic [7:0] CSM = 8'h0a;
    int failures = 0;
    int n_checks = 0;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] ev = 10'h000;
    logic [26:0] link_addr = 27'h0;
    logic [1:0] link_kind = 2'h0, speed = 2'h0, k2;
    logic link_term = 1'b1, ctrl_req = 1'b0, reclaim = 1'b0, tgl_ctrl = 1'b0;
    logic periodic = 1'b0, inact_req = 1'b0, elem_toggle = 1'b0, ovl_toggle = 1'b0;
    logic [3:0] reload = 4'h0;
    logic [10:0] max_pkt = 11'h0, pkt_len = 11'h0;
    logic [31:0] cap = 32'h0, cur = 32'h0, hdw, ecw;
    logic [2:0] uframe_index = 3'h0;
    logic [4:0] frame_index = 5'h0, split_frame_tag;
    logic [6:0] split_bytes = 7'h0, device_address, tt_port_number, tt_hub_address, split_byte_tally;
    logic [26:0] horizontal_link, current_element_link;
    qhd_kind_t descriptor_kind;
    qhd_speed_t endpoint_speed;
    logic [10:0] token_addr, max_packet_bytes, pkt_limit;
    logic [7:0] complete_split_progress, start_split_mask, complete_split_mask;
    logic [3:0] nak_count, endpoint_number;
    logic [1:0] transactions_per_microframe, xact_remaining;
    logic horizontal_valid, follow_next, speed_reserved, control_endpoint, reclaim_head, inactivate_next;
    logic data_toggle, mult_reserved, ss_go, cs_go, pkt_ok, nak_exhausted;

    always #5 clock = ~clock;

    qhd_sw_model u_qhd_sw_model (.link_addr(link_addr), .link_kind(link_kind), .link_term(link_term),
        .reload(reload), .ctrl_req(ctrl_req), .max_pkt(max_pkt), .reclaim(reclaim), .tgl_ctrl(tgl_ctrl),
        .speed(speed), .ep_num(4'h9), .periodic(periodic), .inact_req(inact_req), .dev_addr(7'h5a),
        .horizontal_dword(hdw), .ep_char_dword(ecw));

    qhd_queue_head u_qhd_queue_head (.clock(clock), .rstn(rstn), .qh_load(ev[0]), .horizontal_dword(hdw),
        .ep_char_dword(ecw), .ep_cap_dword(cap), .current_dword(cur), .overlay_toggle(ovl_toggle),
        .overlay_progress(8'h81), .overlay_frame_tag(5'h1f), .overlay_byte_tally(7'h7f),
        .elem_load(ev[1]), .elem_toggle(elem_toggle), .xact_done(ev[2]), .xact_nak_nyet(ev[8]),
        .xact_ack(ev[9]), .uframe_tick(ev[3]), .uframe_index(uframe_index), .frame_index(frame_index),
        .ss_issued(ev[4]), .cs_done(ev[5]), .split_bytes(split_bytes), .pkt_check(ev[6]), .pkt_len(pkt_len),
        .service_done(ev[7]), .horizontal_link(horizontal_link), .descriptor_kind(descriptor_kind),
        .horizontal_valid(horizontal_valid), .current_element_link(current_element_link),
        .follow_next(follow_next), .device_address(device_address), .endpoint_number(endpoint_number),
        .token_addr(token_addr), .endpoint_speed(endpoint_speed), .speed_reserved(speed_reserved),
        .max_packet_bytes(max_packet_bytes), .control_endpoint(control_endpoint),
        .reclaim_head(reclaim_head), .inactivate_next(inactivate_next), .data_toggle(data_toggle),
        .transactions_per_microframe(transactions_per_microframe), .xact_remaining(xact_remaining),
        .mult_reserved(mult_reserved), .tt_port_number(tt_port_number), .tt_hub_address(tt_hub_address),
        .start_split_mask(start_split_mask), .complete_split_mask(complete_split_mask),
        .ss_go(ss_go), .cs_go(cs_go),
        .complete_split_progress(complete_split_progress), .split_frame_tag(split_frame_tag),
        .split_byte_tally(split_byte_tally), .pkt_ok(pkt_ok), .pkt_limit(pkt_limit),
        .nak_count(nak_count), .nak_exhausted(nak_exhausted));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Pulses one set of events for a single cycle and returns once its results have landed.
    task automatic fire(input logic [9:0] m);
        @(posedge clock) ev <= m;
        @(posedge clock) ev <= 10'h000;
        #1;
    endtask

    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // A hang counts as a mismatch and still ends in the normal report.
    initial begin
        #200000;
        failures++;
        results;
    end

    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        #1;
        `CHK(nak_exhausted, 1'b1)
        for (int k = 0; k < 4; k++) begin
            k2 = k[1:0];
            @(posedge clock) begin
                link_addr <= 27'h2abcde0 + 27'(k);
                link_kind <= k2;
                link_term <= k2[0];
                speed <= k2;
                reload <= 4'h3 + 4'(k);
                ctrl_req <= 1'b1;
                reclaim <= k2[0];
                periodic <= 1'b1;
                inact_req <= 1'b1;
                max_pkt <= 11'h200;
                cap <= {k2, 7'h22, 7'h11, CSM, SSM};
                cur <= 32'h12345660 | k;
                ovl_toggle <= k2[0];
            end
            fire(10'h001);
            `CHK(descriptor_kind, qhd_kind_t'(k2))
            `CHK(horizontal_valid, ~k2[0])
            `CHK(horizontal_link, 27'h2abcde0 + 27'(k))
            `CHK(current_element_link, cur[31:5])
            `CHK(nak_count, 4'h3 + 4'(k))
            `CHK(token_addr, {4'h9, 7'h5a})
            `CHK(device_address, 7'h5a)
            `CHK(tt_port_number, 7'h22)
            `CHK(tt_hub_address, 7'h11)
            `CHK(endpoint_speed, qhd_speed_t'(k2))
            `CHK(speed_reserved, k2 == 2'h3)
            `CHK(transactions_per_microframe, k2)
            `CHK(mult_reserved, k2 == 2'h0)
            `CHK(control_endpoint, !k2[1])
            `CHK(inactivate_next, !k2[1])
            `CHK(reclaim_head, k2[0])
            `CHK(max_packet_bytes, 11'h200)
            `CHK(data_toggle, k2[0])
            `CHK(endpoint_number, 4'h9)
            `CHK(start_split_mask, SSM)
            `CHK(complete_split_mask, CSM)
            fire(10'h008);
            `CHK(xact_remaining, k2)
            `CHK(ss_go, !k2[1])
            `CHK(cs_go, 1'b0)
            fire(10'h080);
            `CHK(follow_next, ~k2[0])
        end
        @(posedge clock) begin
            speed <= 2'h0;
            reload <= 4'h2;
            tgl_ctrl <= 1'b0;
            elem_toggle <= 1'b1;
            ovl_toggle <= 1'b0;
        end
        fire(10'h001);
        `CHK(complete_split_progress, 8'h81)
        `CHK(split_frame_tag, 5'h1f)
        `CHK(split_byte_tally, 7'h7f)
        for (int i = 0; i < 3; i++) begin
            fire(10'h104);
            `CHK(nak_count, (i < 2) ? 4'(1 - i) : 4'h0)
            `CHK(nak_exhausted, i > 0)
        end
        fire(10'h105);
        `CHK(nak_count, 4'h2)
        fire(10'h002);
        `CHK(data_toggle, 1'b0)
        fire(10'h204);
        `CHK(data_toggle, 1'b1)
        @(posedge clock) tgl_ctrl <= 1'b1;
        fire(10'h001);
        fire(10'h002);
        `CHK(data_toggle, 1'b1)
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) uframe_index <= 3'(i);
            fire(10'h008);
            `CHK(ss_go, SSM[i])
            `CHK(cs_go, CSM[i])
        end
        @(posedge clock) begin
            frame_index <= 5'h13;
            uframe_index <= 3'h3;
            split_bytes <= 7'h10;
        end
        fire(10'h010);
        `CHK(split_frame_tag, 5'h13)
        `CHK(complete_split_progress, 8'h00)
        `CHK(split_byte_tally, 7'h00)
        fire(10'h020);
        `CHK(complete_split_progress, 8'h08)
        fire(10'h004);
        fire(10'h004);
        `CHK(split_byte_tally, 7'h20)
        for (int j = 0; j < 4; j++) begin
            @(posedge clock) begin
                max_pkt <= (j < 2) ? 11'h7ff : 11'h040;
                pkt_len <= ((j < 2) ? 11'h400 : 11'h040) + 11'(j % 2);
            end
            fire(10'h001);
            fire(10'h040);
            `CHK(pkt_ok, j % 2 == 0)
            `CHK(pkt_limit, (j < 2) ? 11'h400 : 11'h040)
        end
        results;
    end
endmodule

// [tb/qhd_sw_model.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Driver software side: builds the descriptor dwords
// ------------------------------------------------------------
module qhd_sw_model
    import qhd_pkg::*;
(
    // Link request
    input wire logic [26:0] link_addr,
    input wire logic [1:0] link_kind,
    input wire logic link_term,
    // Endpoint request
    input wire logic [3:0] reload,
    input wire logic ctrl_req,
    input wire logic [10:0] max_pkt,
    input wire logic reclaim,
    input wire logic tgl_ctrl,
    input wire logic [1:0] speed,
    input wire logic [3:0] ep_num,
    input wire logic periodic,
    input wire logic inact_req,
    input wire logic [6:0] dev_addr,
    // Descriptor dwords
    output logic [31:0] horizontal_dword,
    output logic [31:0] ep_char_dword
);
    logic ctrl;
    logic inact;

    // Software never marks a high-speed or reserved-speed endpoint as control.
    assign ctrl = ctrl_req && !speed[1];
    // Inactivate only makes sense for a periodic full- or low-speed head.
    assign inact = inact_req && periodic && !speed[1];
    assign horizontal_dword = {link_addr, 2'h0, link_kind, link_term};
    assign ep_char_dword = {reload, ctrl, max_pkt, reclaim, tgl_ctrl, speed, ep_num, inact, dev_addr};
endmodule
